/* File: rtl/comparator_control.sv */
// Comparator digital control: Avalon-MM registers, two channels, pins
`default_nettype none
`include "comparator_params.svh"
module comparator_control
  import comparator_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [`CMP_ADDR_W+1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [1:0] raw_result_in,
  input wire logic timer_fall_in,
  input wire logic [1:0] pin_direction_bit_in,
  output logic [1:0] pin_data_out,
  output logic [1:0] pin_oe_out,
  output logic [1:0] timer_result_out,
  output logic [1:0] comparator_irq_flag_out,
  output analog_cfg_t cfg_one_out,
  output analog_cfg_t cfg_two_out
);
  localparam logic [7:0] CTRL_A_MASK = `CA_WMASK;

  // Mirror and flag words carry one bit per channel, so two is the limit
  if (CHANNELS != 2) begin : bad_channel_count
    $error("comparator_control serves exactly two channels");
  end

  // Word index 5 must fit in the address field
  if (`CMP_ADDR_W < 3) begin : bad_address_width
    $error("comparator_control needs at least three index bits");
  end

  // The result bit is read-only: a writable mask would store it
  if (CTRL_A_MASK[`CA_RESULT] != 1'b0) begin : bad_write_mask
    $error("comparator_control result bit must not be writable");
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer on the second edge
  // A request seen at edge N+1 drops waitrequest for the next cycle.
  // The master samples it low at edge N+2, which is where a write
  // lands; read data are loaded at N+1 so that they stand by then.

  logic busy;
  logic take;
  logic wr_take;
  logic lane_ok;
  logic [`CMP_ADDR_W-1:0] idx;
  logic addr_ok;
  logic [1:0] hit_ctrl_a;
  logic [1:0] hit_ctrl_b;
  logic hit_flags;
  logic [7:0] ctrl_a [2];
  logic [7:0] ctrl_b [2];
  logic [1:0] result;
  logic [1:0] edge_hit;
  logic [1:0] ext_result;
  logic [7:0] read_byte;

  // Only byte lane 0 carries register bits
  assign lane_ok = avs_byteenable_in[0];
  assign take = busy & (avs_read_in | avs_write_in);
  assign wr_take = take & avs_write_in & lane_ok;
  assign idx = avs_address_in[`CMP_ADDR_W+1:2];
  assign addr_ok = (avs_address_in[1:0] == 2'h0);
  assign hit_flags = wr_take & addr_ok & (idx == `CMP_IDX_FLAGS);

  // waitrequest is high at rest and drops for one cycle to accept
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      busy <= 1'b0;
    end else begin
      busy <= (avs_read_in | avs_write_in) & ~busy;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~busy);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers, one pair per channel
  // Word map, byte address four times the index:
  //   0 control A one, 1 control B one, 2 control A two,
  //   3 control B two, 4 result mirror, 5 edge flags (write 1 clears)
  // Writes to read-only or unmapped words match no hit and are dropped

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : chan
      localparam logic [`CMP_ADDR_W-1:0] IDX_A =
        g ? `CMP_IDX_CTRL_A_TWO : `CMP_IDX_CTRL_A_ONE;
      localparam logic [`CMP_ADDR_W-1:0] IDX_B =
        g ? `CMP_IDX_CTRL_B_TWO : `CMP_IDX_CTRL_B_ONE;

      assign hit_ctrl_a[g] = wr_take & addr_ok & (idx == IDX_A);
      assign hit_ctrl_b[g] = wr_take & addr_ok & (idx == IDX_B);

      // Same value for every reset kind; speed bit resets high
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          ctrl_a[g] <= `CA_RESET;
        end else if (hit_ctrl_a[g]) begin
          ctrl_a[g] <= avs_writedata_in[7:0] & `CA_WMASK;
        end
      end

      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          ctrl_b[g] <= `CB_RESET;
        end else if (hit_ctrl_b[g]) begin
          ctrl_b[g] <= avs_writedata_in[7:0] & `CB_WMASK;
        end
      end

      // Readback sees a raw change one edge later, the flag two edges
      // later; pin and timer copies trail the latch by one edge.
      comparator_channel unit (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .raw_result_in(raw_result_in[g]),
        .enable_in(ctrl_a[g][`CA_ENABLE]),
        .invert_in(ctrl_a[g][`CA_INVERT]),
        .sync_in(ctrl_a[g][`CA_SYNC]),
        .rise_en_in(ctrl_b[g][`CB_RISE]),
        .fall_en_in(ctrl_b[g][`CB_FALL]),
        .timer_fall_in(timer_fall_in),
        .result_out(result[g]),
        .edge_out(edge_hit[g]),
        .ext_result_out(ext_result[g])
      );

      // Flag set wins over a software clear in the same cycle
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          comparator_irq_flag_out[g] <= 1'b0;
        end else if (edge_hit[g]) begin
          comparator_irq_flag_out[g] <= 1'b1;
        end else if (hit_flags && avs_writedata_in[g]) begin
          comparator_irq_flag_out[g] <= 1'b0;
        end
      end

      // Pin override is independent of the enable bit
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          pin_oe_out[g] <= 1'b0;
        end else begin
          pin_oe_out[g] <= ctrl_a[g][`CA_PIN_OE] &
                           ~pin_direction_bit_in[g];
        end
      end
    end
  endgenerate

  // Pin and timer copies are registered: one cycle later than the latch
  // The pin copy and the timer copy share one source, so sync mode governs both
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_data_out <= 2'h0;
    end else begin
      pin_data_out <= ext_result;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_result_out <= 2'h0;
    end else begin
      timer_result_out <= ext_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog core configuration
  // The core sees registered copies, so a register write never glitches
  // its switches; reset values match those of the control registers.

  localparam logic [7:0] CTRL_A_INIT = `CA_RESET;
  localparam logic [7:0] CTRL_B_INIT = `CB_RESET;

  localparam analog_cfg_t CFG_ONE_INIT = '{
    comparator_enable: CTRL_A_INIT[`CA_ENABLE],
    speed_power_select: CTRL_A_INIT[`CA_SPEED],
    hysteresis_enable: CTRL_A_INIT[`CA_HYST],
    positive_input_select: src_own_pin,
    negative_input_select: CTRL_B_INIT[`CB_NSEL_HI:`CB_NSEL_LO]
  };
  localparam analog_cfg_t CFG_TWO_INIT = '{
    comparator_enable: CTRL_A_INIT[`CA_ENABLE],
    speed_power_select: CTRL_A_INIT[`CA_SPEED],
    hysteresis_enable: CTRL_A_INIT[`CA_HYST],
    positive_input_select: src_shared_pin,
    negative_input_select: CTRL_B_INIT[`CB_NSEL_HI:`CB_NSEL_LO]
  };

  function automatic analog_cfg_t make_cfg(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic second);
    analog_cfg_t c;
    logic [1:0] p;
    c = '0;
    p = b[`CB_PSEL_HI:`CB_PSEL_LO];
    c.comparator_enable = a[`CA_ENABLE];
    c.speed_power_select = a[`CA_SPEED];
    c.hysteresis_enable = a[`CA_HYST];
    case (p)
      `PSEL_PIN: c.positive_input_select =
        second ? src_shared_pin : src_own_pin;
      `PSEL_DAC: c.positive_input_select = src_dac;
      `PSEL_FIXED: c.positive_input_select = src_fixed_ref;
      `PSEL_ALT: c.positive_input_select =
        second ? src_ground : src_shared_pin;
      default: c.positive_input_select = src_own_pin;
    endcase
    c.negative_input_select = b[`CB_NSEL_HI:`CB_NSEL_LO];
    return c;
  endfunction

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_one_out <= CFG_ONE_INIT;
    end else begin
      cfg_one_out <= make_cfg(ctrl_a[0], ctrl_b[0], 1'b0);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_two_out <= CFG_TWO_INIT;
    end else begin
      cfg_two_out <= make_cfg(ctrl_a[1], ctrl_b[1], 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Result bits come from the latched copies, never from the stored
  // control word, whose result position is masked off on writes
  always_comb begin
    read_byte = 8'h00;
    if (addr_ok) begin
      case (idx)
        `CMP_IDX_CTRL_A_ONE: begin
          read_byte = ctrl_a[0];
          read_byte[`CA_RESULT] = result[0];
        end
        `CMP_IDX_CTRL_B_ONE: read_byte = ctrl_b[0];
        `CMP_IDX_CTRL_A_TWO: begin
          read_byte = ctrl_a[1];
          read_byte[`CA_RESULT] = result[1];
        end
        `CMP_IDX_CTRL_B_TWO: read_byte = ctrl_b[1];
        `CMP_IDX_MIRROR: read_byte = {6'h00, result[1], result[0]};
        `CMP_IDX_FLAGS: read_byte = {6'h00, comparator_irq_flag_out};
        default: read_byte = 8'h00;
      endcase
    end
  end

  // Unmapped addresses read zero; write-only nothing, writes ignored
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if ((avs_read_in | avs_write_in) & ~busy) begin
      avs_readdata_out <= {24'h00_0000, read_byte};
    end
  end
endmodule
`default_nettype wire

/* File: rtl/comparator_params.svh */
// Constants for the comparator control block: offsets, fields, reset values
`ifndef COMPARATOR_PARAMS_SVH
`define COMPARATOR_PARAMS_SVH

// Register word indices (byte address = index * 4)
`define CMP_ADDR_W 4
`define CMP_IDX_CTRL_A_ONE 4'h0
`define CMP_IDX_CTRL_B_ONE 4'h1
`define CMP_IDX_CTRL_A_TWO 4'h2
`define CMP_IDX_CTRL_B_TWO 4'h3
`define CMP_IDX_MIRROR 4'h4
`define CMP_IDX_FLAGS 4'h5

// Control register A fields
`define CA_ENABLE 7
`define CA_RESULT 6
`define CA_PIN_OE 5
`define CA_INVERT 4
`define CA_SPEED 2
`define CA_HYST 1
`define CA_SYNC 0
`define CA_WMASK 8'hB7
`define CA_RESET 8'h04

// Control register B fields
`define CB_RISE 7
`define CB_FALL 6
`define CB_PSEL_HI 5
`define CB_PSEL_LO 4
`define CB_NSEL_HI 1
`define CB_NSEL_LO 0
`define CB_WMASK 8'hF3
`define CB_RESET 8'h00

// Positive input select codes
`define PSEL_PIN 2'h0
`define PSEL_DAC 2'h1
`define PSEL_FIXED 2'h2
`define PSEL_ALT 2'h3

`endif

/* File: rtl/comparator_pkg.sv */
// Types shared by the comparator control block
`default_nettype none
package comparator_pkg;
  // Positive input source as seen by the analog core
  typedef enum logic [2:0] {
    src_own_pin, src_shared_pin, src_dac, src_fixed_ref, src_ground
  } positive_source_t;

  // Per-comparator configuration towards the analog core
  typedef struct packed {
    logic comparator_enable;
    logic speed_power_select;
    logic hysteresis_enable;
    positive_source_t positive_input_select;
    logic [1:0] negative_input_select;
  } analog_cfg_t;
endpackage
`default_nettype wire

/* File: rtl/comparator_channel.sv */
// One comparator's result path: polarity, latch, edge detect, sync latch
`default_nettype none
`include "comparator_params.svh"
module comparator_channel
  import comparator_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic raw_result_in,
  input wire logic enable_in,
  input wire logic invert_in,
  input wire logic sync_in,
  input wire logic rise_en_in,
  input wire logic fall_en_in,
  input wire logic timer_fall_in,
  output logic result_out,
  output logic edge_out,
  output logic ext_result_out
);
  logic polarised;
  logic ext_latch;

  // A disabled core reads as low before polarity; toggling enable or
  // polarity therefore still makes edges that can raise the flag.
  assign polarised = (raw_result_in & enable_in) ^ invert_in;

  // Sampled once per instruction cycle; readback and edges use this copy
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= 1'b0;
    end else begin
      result_out <= polarised;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      edge_out <= 1'b0;
    end else begin
      edge_out <= (rise_en_in & polarised & ~result_out) |
                  (fall_en_in & ~polarised & result_out);
    end
  end

  // Timer clock falling edge arrives as a one-cycle enable, already
  // taken after the prescaler by the timer side.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_latch <= 1'b0;
    end else if (timer_fall_in) begin
      ext_latch <= polarised;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_result_out <= 1'b0;
    end else begin
      ext_result_out <= sync_in ? ext_latch : polarised;
    end
  end
endmodule
`default_nettype wire

/* File: sim/analog_core_model.sv */
// Analog core and timer stand-in: comparison levels and prescaled ticks
`default_nettype none
module analog_core_model
  import comparator_pkg::*;
(
  input wire logic mclk_in,
  input wire logic [1:0] level_in,
  input wire logic tick_in,
  input wire analog_cfg_t cfg_one_in,
  input wire analog_cfg_t cfg_two_in,
  output logic [1:0] raw_result_out,
  output logic timer_fall_out
);
  logic [1:0] prescale = 2'h0;
  initial timer_fall_out = 1'b0;
  // A powered-down core gives no comparison
  assign raw_result_out = level_in &
    {cfg_two_in.comparator_enable, cfg_one_in.comparator_enable};
  ////////////////////////////////////////////////////////////////////////////
  // Strobe follows the divided clock, so a raw tick never latches alone
  always @(posedge mclk_in) begin
    if (tick_in) prescale <= prescale + 2'h1;
    timer_fall_out <= tick_in && prescale == 2'h3;
  end
endmodule
`default_nettype wire

/* File: sim/comparator_control_chk.sv */
// Port checker for the comparator control block
`default_nettype none
module comparator_control_chk
  import comparator_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [1:0] pin_direction_bit_in,
  input wire logic [1:0] pin_data_out,
  input wire logic [1:0] pin_oe_out,
  input wire logic [1:0] timer_result_out,
  input wire logic [1:0] comparator_irq_flag_out,
  input wire analog_cfg_t cfg_one_out,
  input wire analog_cfg_t cfg_two_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_wait_single: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("waitrequest low too long");
  a_wait_cause: assert property (!avs_waitrequest_out |->
    $past(avs_read_in || avs_write_in)) else $error("answer without request");
  a_upper_zero: assert property (
    !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_ctrl_gap: assert property (
    !avs_waitrequest_out && avs_read_in && avs_address_in < 6'h10 |->
    !avs_readdata_out[3]) else $error("control bit 3 set");
  a_mirror_gap: assert property (
    !avs_waitrequest_out && avs_read_in && avs_address_in == 6'h10 |->
    avs_readdata_out[7:2] == 6'h00) else $error("mirror high bits set");
  a_reset_speed: assert property (
    $past(rst_in) |=> cfg_one_out.speed_power_select &&
    cfg_two_out.speed_power_select) else $error("speed not set by reset");
  a_flag_clear: assert property (
    $fell(comparator_irq_flag_out[1]) |-> $past(avs_write_in &&
    !avs_waitrequest_out && avs_address_in == 6'h14 && avs_writedata_in[1]))
    else $error("flag fell without clear");
  a_two_shared: assert property (
    cfg_two_out.positive_input_select != src_own_pin)
    else $error("own pin on comparator two");
  a_one_ground: assert property (
    cfg_one_out.positive_input_select != src_ground)
    else $error("ground on comparator one");
  a_pin_direction: assert property (
    (pin_oe_out & $past(pin_direction_bit_in)) == 2'h0)
    else $error("pin driven while direction is input");
endmodule
bind comparator_control comparator_control_chk u_chk (.mclk_in, .rst_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_readdata_out, .avs_waitrequest_out, .pin_direction_bit_in,
  .pin_data_out, .pin_oe_out,
  .timer_result_out, .comparator_irq_flag_out, .cfg_one_out, .cfg_two_out);
`default_nettype wire

/* File: sim/comparator_control_test.sv */
// Self-checking bench for the comparator control block
`default_nettype none
module comparator_control_test
  import comparator_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h1;
  logic [1:0] level = 2'h0;
  logic tick = 1'b0;
  logic [1:0] dir = 2'h3;
  logic [31:0] rdata, got;
  logic wait_req, tfall;
  logic [1:0] raw, pin_d, pin_oe, tmr, flag;
  analog_cfg_t cfg1, cfg2;
  int bad_count = 0;
  int num_checks = 0;
  always #10 mclk_in = ~mclk_in;
  comparator_control DUT (.mclk_in, .rst_in, .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .raw_result_in(raw),
    .timer_fall_in(tfall), .pin_direction_bit_in(dir), .pin_data_out(pin_d),
    .pin_oe_out(pin_oe), .timer_result_out(tmr),
    .comparator_irq_flag_out(flag), .cfg_one_out(cfg1), .cfg_two_out(cfg2));
  analog_core_model model (.mclk_in, .level_in(level), .tick_in(tick),
    .cfg_one_in(cfg1), .cfg_two_in(cfg2), .raw_result_out(raw),
    .timer_fall_out(tfall));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic is_wr, input logic [5:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    addr <= a;
    wdata <= {24'h000000, d};
    wr <= is_wr;
    rd <= !is_wr;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    got = rdata;
    if (n >= 50) chk("bus answer", 32'h0, 32'h1);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rreg(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk("register read", exp, got);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rreg(6'h00, 32'h04);
    rreg(6'h04, 32'h00);
    rreg(6'h08, 32'h04);
    rreg(6'h10, 32'h00);
    rreg(6'h3C, 32'h00);
    be <= 4'h0;
    bus(1'b1, 6'h00, 8'hFF);
    be <= 4'h1;
    rreg(6'h00, 32'h04);
  endtask
  task automatic t_fields();
    analog_cfg_t e;
    e = '{1'b1, 1'b1, 1'b1, src_shared_pin, 2'h3};
    bus(1'b1, 6'h00, 8'hFF);
    rreg(6'h00, 32'hF7);
    rreg(6'h10, 32'h01);
    bus(1'b1, 6'h04, 8'hFF);
    rreg(6'h04, 32'hF3);
    cyc(2);
    chk("cfg one", {24'h0, e}, {24'h0, cfg1});
  endtask
  task automatic t_select();
    positive_source_t p1[4] = '{src_own_pin, src_dac, src_fixed_ref,
                                src_shared_pin};
    positive_source_t p2[4] = '{src_shared_pin, src_dac, src_fixed_ref,
                                src_ground};
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 6'h04, {2'h0, 2'(c), 2'h0, 2'(c)});
      bus(1'b1, 6'h0C, {2'h0, 2'(c), 2'h0, 2'(3 - c)});
      cyc(2);
      chk("pos one", {29'h0, p1[c]}, {29'h0, cfg1.positive_input_select});
      chk("pos two", {29'h0, p2[c]}, {29'h0, cfg2.positive_input_select});
      chk("neg two", 32'(3 - c), {30'h0, cfg2.negative_input_select});
    end
  endtask
  task automatic t_edges();
    bus(1'b1, 6'h08, 8'h80);
    bus(1'b1, 6'h0C, 8'h80);
    bus(1'b1, 6'h14, 8'h03);
    cyc(2);
    chk("low power", 32'h0, {31'h0, cfg2.speed_power_select});
    level <= 2'h2;
    cyc(4);
    chk("rise flag", 32'h1, {31'h0, flag[1]});
    rreg(6'h10, 32'h03);
    bus(1'b1, 6'h14, 8'h02);
    cyc(2);
    chk("flag clear", 32'h0, {31'h0, flag[1]});
    level <= 2'h0;
    cyc(4);
    chk("fall off", 32'h0, {31'h0, flag[1]});
    bus(1'b1, 6'h0C, 8'h40);
    level <= 2'h2;
    cyc(4);
    chk("rise off", 32'h0, {31'h0, flag[1]});
    level <= 2'h0;
    cyc(4);
    chk("fall flag", 32'h1, {31'h0, flag[1]});
    bus(1'b1, 6'h08, 8'h00);
    bus(1'b1, 6'h0C, 8'hC0);
    bus(1'b1, 6'h14, 8'h02);
    bus(1'b1, 6'h08, 8'h10);
    cyc(4);
    rreg(6'h14, 32'h02);
  endtask
  task automatic t_sync();
    dir <= 2'h2;
    bus(1'b1, 6'h00, 8'hA5);
    level <= 2'h1;
    cyc(5);
    chk("held by sync", 32'h0, {31'h0, tmr[0]});
    chk("pin driven", 32'h1, {31'h0, pin_oe[0]});
    tick <= 1'b1;
    cyc(8);
    tick <= 1'b0;
    cyc(3);
    chk("timer latch", 32'h1, {31'h0, tmr[0]});
    chk("pin level", 32'h1, {31'h0, pin_d[0]});
    dir <= 2'h3;
    cyc(3);
    chk("pin input", 32'h0, {31'h0, pin_oe[0]});
    bus(1'b1, 6'h00, 8'h24);
    dir <= 2'h2;
    cyc(4);
    chk("async low", 32'h0, {31'h0, tmr[0]});
    chk("oe while off", 32'h1, {31'h0, pin_oe[0]});
    bus(1'b1, 6'h00, 8'h34);
    cyc(4);
    chk("async invert", 32'h1, {31'h0, tmr[0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst_in <= 1'b0;
    t_reset();
    t_fields();
    t_select();
    t_edges();
    t_sync();
    end_of_test();
  end
  // Whole run needs well under two thousand cycles
  initial begin
    cyc(20000);
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
